// >>> common/pfs_pkg.sv
// Purpose: Shared constants and types for the pin function select block
// Assumes: Avalon-MM register bus with 32-bit data, one word per register
// Notes: Offsets are byte addresses

package pfs_pkg;
   // Register byte offsets
   localparam logic [4:0] OFS_PB_LOW = 5'h00;
   localparam logic [4:0] OFS_PB_HIGH = 5'h04;
   localparam logic [4:0] OFS_PC_LOW = 5'h08;
   localparam logic [4:0] OFS_PC_HIGH = 5'h0C;
   localparam logic [4:0] OFS_PD = 5'h10;
   localparam logic [4:0] OFS_IN_SRC = 5'h14;
   localparam logic [4:0] OFS_PORT_DATA = 5'h18;
   localparam logic [4:0] OFS_PORT_DIR = 5'h1C;
   // Reset values
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] PORT_RESET = 8'hFF;
   // Implemented bits of the six-bit select registers
   localparam logic [7:0] SIX_BIT_MASK = 8'h3F;
   // Field positions inside input_source_select
   localparam int IRQ1_SRC_BIT = 5;
   localparam int IRQ0_SRC_BIT = 4;
   localparam int SDI_SRC_BIT = 3;
   localparam int SCK_SRC_BIT = 2;
   localparam int CS_SRC_BIT = 1;
   localparam int RX_SRC_BIT = 0;
   // Function codes of a two-bit select field
   localparam logic [1:0] FN_GPIO = 2'h0;
   localparam logic [1:0] FN_ALT1 = 2'h1;
   localparam logic [1:0] FN_ALT2 = 2'h2;
   localparam logic [1:0] FN_ALT3 = 2'h3;

   // Bus request group
   typedef struct packed {
      logic [4:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } pfs_req_t;

   // Peripheral outputs that may reach pins
   typedef struct packed {
      logic ctOut;
      logic stOut;
      logic ptOut;
      logic clkOut;
      logic uartTx;
      logic sdo;
      logic sckOut;
      logic sckOe;
      logic sdaOut;
      logic sdaOe;
   } pfs_periph_t;

   // Inputs routed back to peripherals
   typedef struct packed {
      logic irq0;
      logic irq1;
      logic stClk;
      logic sdi;
      logic sck;
      logic cs;
      logic uartRx;
   } pfs_route_t;
endpackage : pfs_pkg

// >>> rtl/pfs_pin_select.sv
// Purpose: Pin function multiplexer for ports B, C and D
// Assumes: Avalon-MM slave, answers reads and writes one cycle late
// Notes: Peripherals themselves live outside this block
//
// Contract
// - PB3 select: gpio, compact timer, lcd11, an7
// - PB2 select: gpio/timer clock, timer, lcd10, an2
// - PB1 select: gpio/irq1, lcd9, an1, xtal2
// - PB0 select: gpio/irq0, lcd8, an0, xtal1
// - Unimplemented bits 7..6 read zero
// - PB6 select: gpio, sck, comparator plus, lcd14
// - PB5 select: gpio, chip select, comparator minus, lcd13
// - PB4 select: gpio, clock out, lcd12, an8
// - PC3 select: gpio, gpio, sdo, lcd18
// - PC2 select: gpio, gpio, sdo, lcd17
// - PC1 select: gpio, uart rx, lcd16, high_speed_crystal_pin2
// - PC0 select: gpio, uart tx, lcd15, high_speed_crystal_pin1
// - PC6 select: gpio, gpio, chip select, lcd21
// - PC5/PC4 select: gpio, gpio, sck/sda, lcd
// - PD3 select: gpio, compact timer, seg25, an9
// - PD2 select: gpio, uart tx, seg24, an10
// - PD1 select: gpio, uart rx, seg23, an11
// - PD0 select: gpio, gpio, periodic timer, seg22
// - Irq sources pick port B or A
// - Serial input sources pick first or second pin
// - Port data and direction reset to ones
// - Port A falling edge wakes sleeping device
`timescale 1ns/100ps

module pfs_pin_select (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] portAIn,
   input wire logic [6:0] portBIn,
   input wire logic [6:0] portCIn,
   input wire logic [3:0] portDIn,
   output logic [6:0] portBOut,
   output logic [6:0] portBOe,
   output logic [6:0] portCOut,
   output logic [6:0] portCOe,
   output logic [3:0] portDOut,
   output logic [3:0] portDOe,
   output logic [6:0] portBAnalog,
   output logic [6:0] portCAnalog,
   output logic [3:0] portDAnalog,
   input wire pfs_pkg::pfs_periph_t periph,
   output pfs_pkg::pfs_route_t route,
   input wire logic [7:0] wakeEnable,
   input wire logic lowPower,
   output logic wakeUp
);
   // Bus handshake states
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } pfs_bus_t;

   // All module state in one struct
   typedef struct packed {
      pfs_bus_t bus;
      logic [7:0] pbLow;
      logic [7:0] pbHigh;
      logic [7:0] pcLow;
      logic [7:0] pcHigh;
      logic [7:0] pdSel;
      logic [7:0] inSrc;
      logic [23:0] portData; // D,C,B data bytes
      logic [23:0] portDir;  // Ones mean input
      logic [31:0] rdata;
   } pfs_state_t;

   pfs_state_t st;
   pfs_state_t next_st;

   // Two-bit field of a select register
   function automatic logic [1:0] field(input logic [7:0] r,
                                        input int pin);
      field = r[2*pin +: 2];
   endfunction : field

   // Write byte lane zero under byte enable
   function automatic logic [7:0] lane0(input logic [7:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
      lane0 = be[0] ? wd[7:0] : old;
   endfunction : lane0

   // Bus and register next state
   always_comb begin
      next_st = st;
      next_st.bus = BUS_IDLE;
      if (avs_read || avs_write) begin
         next_st.bus = st.bus == BUS_IDLE ? BUS_ACK : BUS_IDLE;
         next_st.rdata = 32'h0000_0000;
         if (avs_address == pfs_pkg::OFS_PB_LOW) begin
            next_st.rdata[7:0] = st.pbLow;
            if (avs_write && st.bus == BUS_ACK) begin
               next_st.pbLow = lane0(st.pbLow, avs_writedata,
                                     avs_byteenable);
            end
         end else if (avs_address == pfs_pkg::OFS_PB_HIGH) begin
            next_st.rdata[7:0] = st.pbHigh;
            if (avs_write && st.bus == BUS_ACK) begin
               next_st.pbHigh = lane0(st.pbHigh, avs_writedata,
                  avs_byteenable) & pfs_pkg::SIX_BIT_MASK;
            end
         end else if (avs_address == pfs_pkg::OFS_PC_LOW) begin
            next_st.rdata[7:0] = st.pcLow;
            if (avs_write && st.bus == BUS_ACK) begin
               next_st.pcLow = lane0(st.pcLow, avs_writedata,
                                     avs_byteenable);
            end
         end else if (avs_address == pfs_pkg::OFS_PC_HIGH) begin
            next_st.rdata[7:0] = st.pcHigh;
            if (avs_write && st.bus == BUS_ACK) begin
               next_st.pcHigh = lane0(st.pcHigh, avs_writedata,
                  avs_byteenable) & pfs_pkg::SIX_BIT_MASK;
            end
         end else if (avs_address == pfs_pkg::OFS_PD) begin
            next_st.rdata[7:0] = st.pdSel;
            if (avs_write && st.bus == BUS_ACK) begin
               next_st.pdSel = lane0(st.pdSel, avs_writedata,
                                     avs_byteenable);
            end
         end else if (avs_address == pfs_pkg::OFS_IN_SRC) begin
            next_st.rdata[7:0] = st.inSrc;
            if (avs_write && st.bus == BUS_ACK) begin
               next_st.inSrc = lane0(st.inSrc, avs_writedata,
                  avs_byteenable) & pfs_pkg::SIX_BIT_MASK;
            end
         end else if (avs_address == pfs_pkg::OFS_PORT_DATA) begin
            next_st.rdata[23:0] = st.portData;
            if (avs_write && st.bus == BUS_ACK) begin
               for (int i = 0; i < 3; i++) begin
                  if (avs_byteenable[i]) begin
                     next_st.portData[8*i +: 8] = avs_writedata[8*i +: 8];
                  end
               end
            end
         end else if (avs_address == pfs_pkg::OFS_PORT_DIR) begin
            next_st.rdata[23:0] = st.portDir;
            if (avs_write && st.bus == BUS_ACK) begin
               for (int i = 0; i < 3; i++) begin
                  if (avs_byteenable[i]) begin
                     next_st.portDir[8*i +: 8] = avs_writedata[8*i +: 8];
                  end
               end
            end
         end else begin
            // Unmapped: read zero, write ignored
            next_st.rdata = 32'h0000_0000;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st.bus <= BUS_IDLE;
         st.pbLow <= pfs_pkg::SEL_RESET;
         st.pbHigh <= pfs_pkg::SEL_RESET;
         st.pcLow <= pfs_pkg::SEL_RESET;
         st.pcHigh <= pfs_pkg::SEL_RESET;
         st.pdSel <= pfs_pkg::SEL_RESET;
         st.inSrc <= pfs_pkg::SEL_RESET;
         st.portData <= {3{pfs_pkg::PORT_RESET}};
         st.portDir <= {3{pfs_pkg::PORT_RESET}};
         st.rdata <= 32'h0000_0000;
      end else begin
         st <= next_st;
      end
   end

   // Bus answer: wait one cycle, then release
   assign avs_waitrequest = (avs_read || avs_write) && st.bus == BUS_IDLE;
   assign avs_readdata = st.rdata;

   // Port B pin routing
   always_comb begin
      logic [1:0] f;
      f = 2'h0;
      portBOut = st.portData[6:0];
      portBOe = ~st.portDir[6:0];
      portBAnalog = 7'h00;
      // PB0 and PB1 gpio or analog/crystal
      for (int p = 0; p < 2; p++) begin
         f = field(st.pbLow, p);
         if (f != pfs_pkg::FN_GPIO) begin
            portBOe[p] = 1'b0;
            portBAnalog[p] = 1'b1;
         end
      end
      // PB2 standard timer
      f = field(st.pbLow, 2);
      if (f == pfs_pkg::FN_ALT1) begin
         portBOut[2] = periph.stOut;
         portBOe[2] = 1'b1;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portBOe[2] = 1'b0;
         portBAnalog[2] = 1'b1;
      end
      // PB3 compact timer
      f = field(st.pbLow, 3);
      if (f == pfs_pkg::FN_ALT1) begin
         portBOut[3] = periph.ctOut;
         portBOe[3] = 1'b1;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portBOe[3] = 1'b0;
         portBAnalog[3] = 1'b1;
      end
      // PB4 clock output
      f = field(st.pbHigh, 0);
      if (f == pfs_pkg::FN_ALT1) begin
         portBOut[4] = periph.clkOut;
         portBOe[4] = 1'b1;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portBOe[4] = 1'b0;
         portBAnalog[4] = 1'b1;
      end
      // PB5 chip select input, comparator, lcd
      f = field(st.pbHigh, 1);
      if (f == pfs_pkg::FN_ALT1) begin
         portBOe[5] = 1'b0;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portBOe[5] = 1'b0;
         portBAnalog[5] = 1'b1;
      end
      // PB6 serial clock
      f = field(st.pbHigh, 2);
      if (f == pfs_pkg::FN_ALT1) begin
         portBOut[6] = periph.sckOut;
         portBOe[6] = periph.sckOe;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portBOe[6] = 1'b0;
         portBAnalog[6] = 1'b1;
      end
   end

   // Port C pin routing
   always_comb begin
      logic [1:0] f;
      f = 2'h0;
      portCOut = st.portData[14:8];
      portCOe = ~st.portDir[14:8];
      portCAnalog = 7'h00;
      // PC0 uart tx, PC1 uart rx
      f = field(st.pcLow, 0);
      if (f == pfs_pkg::FN_ALT1) begin
         portCOut[0] = periph.uartTx;
         portCOe[0] = 1'b1;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portCOe[0] = 1'b0;
         portCAnalog[0] = 1'b1;
      end
      f = field(st.pcLow, 1);
      if (f == pfs_pkg::FN_ALT1) begin
         portCOe[1] = 1'b0;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portCOe[1] = 1'b0;
         portCAnalog[1] = 1'b1;
      end
      // PC2 and PC3 serial data out; 00 and 01 both gpio
      for (int p = 2; p < 4; p++) begin
         f = field(st.pcLow, p);
         if (f == pfs_pkg::FN_ALT2) begin
            portCOut[p] = periph.sdo;
            portCOe[p] = 1'b1;
         end else if (f == pfs_pkg::FN_ALT3) begin
            portCOe[p] = 1'b0;
            portCAnalog[p] = 1'b1;
         end
      end
      // PC4 sda, PC5 sck, PC6 chip select
      f = field(st.pcHigh, 0);
      if (f == pfs_pkg::FN_ALT2) begin
         portCOut[4] = periph.sdaOut;
         portCOe[4] = periph.sdaOe;
      end else if (f == pfs_pkg::FN_ALT3) begin
         portCOe[4] = 1'b0;
         portCAnalog[4] = 1'b1;
      end
      f = field(st.pcHigh, 1);
      if (f == pfs_pkg::FN_ALT2) begin
         portCOut[5] = periph.sckOut;
         portCOe[5] = periph.sckOe;
      end else if (f == pfs_pkg::FN_ALT3) begin
         portCOe[5] = 1'b0;
         portCAnalog[5] = 1'b1;
      end
      f = field(st.pcHigh, 2);
      if (f == pfs_pkg::FN_ALT2) begin
         portCOe[6] = 1'b0;
      end else if (f == pfs_pkg::FN_ALT3) begin
         portCOe[6] = 1'b0;
         portCAnalog[6] = 1'b1;
      end
   end

   // Port D pin routing
   always_comb begin
      logic [1:0] f;
      f = 2'h0;
      portDOut = st.portData[19:16];
      portDOe = ~st.portDir[19:16];
      portDAnalog = 4'h0;
      // PD0 periodic timer; 00 and 01 both gpio
      f = field(st.pdSel, 0);
      if (f == pfs_pkg::FN_ALT2) begin
         portDOut[0] = periph.ptOut;
         portDOe[0] = 1'b1;
      end else if (f == pfs_pkg::FN_ALT3) begin
         portDOe[0] = 1'b0;
         portDAnalog[0] = 1'b1;
      end
      // PD1 uart rx
      f = field(st.pdSel, 1);
      if (f != pfs_pkg::FN_GPIO) begin
         portDOe[1] = 1'b0;
         portDAnalog[1] = (f != pfs_pkg::FN_ALT1);
      end
      // PD2 uart tx
      f = field(st.pdSel, 2);
      if (f == pfs_pkg::FN_ALT1) begin
         portDOut[2] = periph.uartTx;
         portDOe[2] = 1'b1;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portDOe[2] = 1'b0;
         portDAnalog[2] = 1'b1;
      end
      // PD3 compact timer
      f = field(st.pdSel, 3);
      if (f == pfs_pkg::FN_ALT1) begin
         portDOut[3] = periph.ctOut;
         portDOe[3] = 1'b1;
      end else if (f != pfs_pkg::FN_GPIO) begin
         portDOe[3] = 1'b0;
         portDAnalog[3] = 1'b1;
      end
   end

   // Input source routing to peripherals
   always_comb begin
      route.irq1 = st.inSrc[pfs_pkg::IRQ1_SRC_BIT] ? portAIn[2]
                                                  : portBIn[1];
      route.irq0 = st.inSrc[pfs_pkg::IRQ0_SRC_BIT] ? portAIn[1]
                                                  : portBIn[0];
      route.sdi = st.inSrc[pfs_pkg::SDI_SRC_BIT] ? portAIn[3]
                                                : portCIn[4];
      route.sck = st.inSrc[pfs_pkg::SCK_SRC_BIT] ? portBIn[6]
                                                : portCIn[5];
      route.cs = st.inSrc[pfs_pkg::CS_SRC_BIT] ? portBIn[5]
                                              : portCIn[6];
      route.uartRx = st.inSrc[pfs_pkg::RX_SRC_BIT] ? portCIn[1]
                                                  : portDIn[1];
      route.stClk = portBIn[2];
   end

   // Port A wake detector
   pfs_wake_detect u_wake (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .portAIn(portAIn),
      .wakeEnable(wakeEnable),
      .lowPower(lowPower),
      .wakeUp(wakeUp)
   );
endmodule : pfs_pin_select

// >>> rtl/pfs_wake_detect.sv
// Purpose: Port A falling-edge wake detector
// Assumes: Port A inputs synchronous to core_clk
// Notes: Wake pulse only while the core sleeps or idles
`timescale 1ns/100ps

module pfs_wake_detect (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] portAIn,
   input wire logic [7:0] wakeEnable,
   input wire logic lowPower,
   output logic wakeUp
);
   // All state in one struct
   typedef struct packed {
      logic [7:0] lastA;
      logic wake;
   } pfs_wake_state_t;

   pfs_wake_state_t st;
   pfs_wake_state_t next_st;

   // Next state: catch high-to-low on enabled pins
   always_comb begin
      next_st = st;
      next_st.lastA = portAIn;
      next_st.wake = lowPower &&
         (|(st.lastA & ~portAIn & wakeEnable));
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         // Load the live pins so a low pin is not taken for a fall
         st <= '{lastA: portAIn, wake: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign wakeUp = st.wake;
endmodule : pfs_wake_detect

// >>> verification/pfs_pin_select_props.sv
// Purpose: Port-level checks for the pin function select block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound onto every pin select instance
`timescale 1ns/100ps

module pfs_pin_select_props (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [7:0] portAIn,
   input wire logic [6:0] portBIn,
   input wire logic [6:0] portBOe,
   input wire logic [6:0] portCOe,
   input wire logic [3:0] portDOe,
   input wire logic [6:0] portBAnalog,
   input wire logic [6:0] portCAnalog,
   input wire logic [3:0] portDAnalog,
   input wire pfs_pkg::pfs_route_t route,
   input wire logic [7:0] wakeEnable,
   input wire logic lowPower,
   input wire logic wakeUp
);
   logic [7:0] prevA; // Port A one edge back
   logic fallHit; // Enabled fall while in low power
   logic [1:0] armed; // Edges since reset release
   wire logic req = avs_read || avs_write; // Any bus request

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Reference wake detector, gated until it has history
   always_ff @(posedge core_clk) begin
      prevA <= portAIn;
      fallHit <= lowPower && |(prevA & ~portAIn & wakeEnable);
      armed <= !rst_n ? 2'h0 : (armed == 2'h3 ? armed : armed + 2'h1);
   end

   wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
      else $error("no wait cycle on a new request");
   wait_one_a: assert property (avs_waitrequest |=> !avs_waitrequest)
      else $error("wait lasted more than one cycle");
   idle_free_a: assert property (!req |-> !avs_waitrequest)
      else $error("wait raised without a request");
   data_hold_a: assert property (!req && !$past(req) |-> $stable(avs_readdata))
      else $error("read data moved while idle");
   reset_state_a: assert property ($rose(rst_n) |-> portBOe == 7'h00 &&
      portCOe == 7'h00 && portDOe == 4'h0 && !wakeUp)
      else $error("pins not released after reset");
   stclk_follow_a: assert property (route.stClk == portBIn[2])
      else $error("timer clock not following its pin");
   analog_float_a: assert property ((portBAnalog & portBOe) == 7'h00 &&
      (portCAnalog & portCOe) == 7'h00 && (portDAnalog & portDOe) == 4'h0)
      else $error("analog pin is being driven");
   wake_match_a: assert property (armed == 2'h3 |-> wakeUp == fallHit)
      else $error("wake pulse does not match port A falls");

   read_done_c: cover property (avs_read && !avs_waitrequest);
   wake_seen_c: cover property (wakeUp);
   analog_use_c: cover property (|portCAnalog);
endmodule : pfs_pin_select_props

bind pfs_pin_select pfs_pin_select_props u_props (.core_clk, .rst_n,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .portAIn,
   .portBIn, .portBOe, .portCOe, .portDOe, .portBAnalog, .portCAnalog,
   .portDAnalog, .route, .wakeEnable, .lowPower, .wakeUp);

// >>> verification/test_pfs_pin_select.sv
// Purpose: Self-checking bench for the pin function select block
// Assumes: Avalon-MM master with one request in flight
// Notes: Register, mux and wake model compared at every result
`timescale 1ns/100ps

module test_pfs_pin_select;
   logic core_clk; // 20 MHz system clock
   logic rst_n; // Sync reset, active low
   pfs_pkg::pfs_req_t req; // Bus request group
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, lowPower, wakeUp, wakeExp;
   logic [7:0] portAIn, wakeEnable, prevA;
   logic [6:0] portBIn, portCIn, portBOut, portBOe, portCOut, portCOe;
   logic [6:0] portBAnalog, portCAnalog;
   logic [3:0] portDIn, portDOut, portDOe, portDAnalog;
   pfs_pkg::pfs_periph_t periph; // Peripheral drive values
   pfs_pkg::pfs_route_t route; // Routed peripheral inputs
   int err_count = 0, checks = 0, seed = 80, wk = 0;
   logic [31:0] mdl [8]; // Register file model, one word each
   // Function kind per pin and code: G gpio, A analog, I input,
   // X bidirectional serial, lower case names the output driven
   string kinds [18] = '{"GAAA", "GAAA", "GsAA", "GcAA", "GkAA", "GIAA",
      "GXAA", "GtAA", "GIAA", "GGdA", "GGdA", "GGXA", "GGXA", "GGIA",
      "GGpA", "GIAA", "GtAA", "GcAA"};

   pfs_pin_select dut (.core_clk, .rst_n, .avs_address(req.address),
      .avs_read(req.read), .avs_write(req.write),
      .avs_writedata(req.writedata), .avs_byteenable(req.byteenable),
      .avs_readdata, .avs_waitrequest, .portAIn, .portBIn, .portCIn,
      .portDIn, .portBOut, .portBOe, .portCOut, .portCOe, .portDOut,
      .portDOe, .portBAnalog, .portCAnalog, .portDAnalog, .periph, .route,
      .wakeEnable, .lowPower, .wakeUp);

   // Free-running clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Compare one result with the model
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Verdict and end of run
   task automatic final_report;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // Implemented bits of each register
   function automatic logic [31:0] mask(input int i);
      if (i > 5) return 32'h00FFFFFF;
      return i % 2 ? 32'h0000003F : 32'h000000FF;
   endfunction : mask

   // Peripheral output named by a kind letter
   function automatic logic field(input byte k);
      case (k)
         "c": return periph.ctOut;
         "s": return periph.stOut;
         "k": return periph.clkOut;
         "t": return periph.uartTx;
         "d": return periph.sdo;
         default: return periph.ptOut;
      endcase
   endfunction : field

   // One transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge core_clk);
      req <= '{address: a, read: !w, write: w, writedata: d,
         byteenable: 4'hF};
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         n++;
         @(posedge core_clk);
      end
      if (n == 100) chk("waitrequest", 32'h0, 32'h1);
      r = avs_readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask : bus

   // Write a register and update the model
   task automatic wr(input int i, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, 5'(4 * i), d, r);
      mdl[i] = d & mask(i);
   endtask : wr

   // Read every register and compare
   task automatic rd_all;
      logic [31:0] r;
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 5'(4 * i), 32'h0, r);
         chk($sformatf("reg %0d", i), mdl[i], r);
      end
   endtask : rd_all

   // Reset for 16 cycles and reload the model
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      mdl = '{0, 0, 0, 0, 0, 0, 32'h00FFFFFF, 32'h00FFFFFF};
   endtask : do_reset

   // Fresh random pin, peripheral and wake inputs
   task automatic stir;
      @(posedge core_clk);
      portAIn <= 8'($random(seed));
      portBIn <= 7'($random(seed));
      portCIn <= 7'($random(seed));
      portDIn <= 4'($random(seed));
      periph <= 10'($random(seed));
      wakeEnable <= 8'($random(seed));
      lowPower <= 1'($random(seed));
   endtask : stir

   // Compare every pin and routed input with the model
   task automatic pins;
      logic [17:0] o, oe, an;
      pfs_pkg::pfs_route_t r;
      logic [5:0] s;
      logic xo, xe;
      int b, sh, rg, pt;
      byte k;
      o = {portDOut, portCOut, portBOut};
      oe = {portDOe, portCOe, portBOe};
      an = {portDAnalog, portCAnalog, portBAnalog};
      for (int p = 0; p < 18; p++) begin
         pt = p < 7 ? 0 : (p < 14 ? 1 : 2);
         b = p - 7 * pt;
         rg = pt == 2 ? 4 : 2 * pt + int'(b > 3);
         sh = 2 * (b > 3 ? b - 4 : b);
         k = kinds[p][(mdl[rg] >> sh) & 3];
         chk("analog", k == "A", an[p]);
         if (k == "G") begin
            chk("gpio out", mdl[6][8 * pt + b], o[p]);
            chk("gpio oe", !mdl[7][8 * pt + b], oe[p]);
         end else if (k == "I") begin
            chk("input oe", 1'b0, oe[p]);
         end else if (k == "X") begin
            // Serial pins: PC4 carries data, PB6 and PC5 the clock
            {xo, xe} = p == 11 ? {periph.sdaOut, periph.sdaOe}
               : {periph.sckOut, periph.sckOe};
            chk("serial out", xo, o[p]);
            chk("serial oe", xe, oe[p]);
         end else if (k >= "a") begin
            chk("alt out", field(k), o[p]);
            chk("alt oe", 1'b1, oe[p]);
         end
      end
      s = mdl[5][5:0];
      r.irq0 = s[4] ? portAIn[1] : portBIn[0];
      r.irq1 = s[5] ? portAIn[2] : portBIn[1];
      r.stClk = portBIn[2];
      r.sdi = s[3] ? portAIn[3] : portCIn[4];
      r.sck = s[2] ? portBIn[6] : portCIn[5];
      r.cs = s[1] ? portBIn[5] : portCIn[6];
      r.uartRx = s[0] ? portCIn[1] : portDIn[1];
      chk("route", r, route);
   endtask : pins

   // Wake model, compared one edge after each sample
   always @(posedge core_clk) begin
      if (wk == 3) chk("wakeUp", wakeExp, wakeUp);
      wakeExp = lowPower & |(prevA & ~portAIn & wakeEnable);
      prevA = portAIn;
      wk = !rst_n ? 0 : (wk < 3 ? wk + 1 : 3);
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      final_report;
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      req = '0;
      {portAIn, portBIn, portCIn, portDIn, wakeEnable, lowPower} = '0;
      periph = '0;
      do_reset;
      rd_all;
      repeat (40) begin
         for (int i = 0; i < 8; i++) wr(i, $random(seed));
         bus(1'b1, 5'h03, $random(seed), q);
         bus(1'b0, 5'h03, 32'h0, q);
         chk("unmapped", 32'h0, q);
         rd_all;
         stir;
         @(negedge core_clk);
         pins;
      end
      repeat (300) stir;
      do_reset;
      rd_all;
      @(negedge core_clk);
      pins;
      final_report;
   end
endmodule : test_pfs_pin_select
